// File: core/crf_addr_gen.sv
// address masking per mode and even alignment for wide accesses
`timescale 1ns/10ps
module crf_addr_gen (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire crf_pkg::crf_mode_t mode,
    input  wire logic [31:0]        effAddr,
    input  wire logic               wideAccess,
    output logic [23:0]             busAddr
);
    typedef struct packed {
        logic [23:0] addr;
    } crf_agen_state_t;

    crf_agen_state_t st;
    crf_agen_state_t next_st;

    always_comb begin
        next_st = st;
        // RULE_22: normal mode limits to 64 kbytes
        case (mode)
            crf_pkg::MODE_NORMAL: next_st.addr = {8'h00, effAddr[15:0]};
            // RULE_23: upper four bits ignored
            crf_pkg::MODE_MBYTE:  next_st.addr = {4'h0, effAddr[19:0]};
            default:              next_st.addr = effAddr[23:0];
        endcase
        // RULE_21: odd wide access goes even
        if (wideAccess) begin
            next_st.addr[0] = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busAddr = st.addr;
endmodule

// File: core/crf_gp_bank.sv
// general register bank with sub-word write merging
`timescale 1ns/10ps
module crf_gp_bank #(
    parameter int COUNT = crf_pkg::GP_COUNT
) (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire crf_pkg::crf_gp_wr_t wr,
    input  wire logic [2:0]         rdIdxA,
    input  wire logic [2:0]         rdIdxB,
    output logic [31:0]             rdDataA,
    output logic [31:0]             rdDataB,
    output logic [31:0]             stackPointer
);
    typedef struct packed {
        logic [COUNT-1:0][31:0] gp;
        logic [31:0]            rdB;
    } crf_bank_state_t;

    crf_bank_state_t st;
    crf_bank_state_t next_st;

    always_comb begin
        next_st = st;
        // RULE_25: merge partial writes
        if (wr.en) begin
            case (wr.view)
                crf_pkg::VIEW_LONG: next_st.gp[wr.idx] = wr.data;
                crf_pkg::VIEW_EXT:  next_st.gp[wr.idx][31:16] = wr.data[15:0];
                crf_pkg::VIEW_WORD: next_st.gp[wr.idx][15:0] = wr.data[15:0];
                crf_pkg::VIEW_HIGH: next_st.gp[wr.idx][15:8] = wr.data[7:0];
                crf_pkg::VIEW_LOW:  next_st.gp[wr.idx][7:0] = wr.data[7:0];
                default:            next_st.gp[wr.idx] = st.gp[wr.idx];
            endcase
        end
        next_st.rdB = next_st.gp[rdIdxB];
    end

    // contents stay undefined by design; only the port B read register is cleared
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st.rdB <= 32'h0;
            st.gp  <= next_st.gp;
        end else begin
            st <= next_st;
        end
    end

    assign rdDataA      = next_st.gp[rdIdxA];
    assign rdDataB      = st.rdB;
    // RULE_04: seven is stack pointer
    assign stackPointer = st.gp[crf_pkg::SP_INDEX];
endmodule

// File: core/crf_pkg.sv
// package: register file widths, views, flag positions and operation codes
package crf_pkg;
    localparam int GP_COUNT     = 8;
    localparam int GP_WIDTH     = 32;
    localparam int PC_WIDTH     = 24;
    localparam int SP_INDEX     = 7;
    localparam int NORMAL_AW    = 16;
    localparam int MBYTE_AW     = 20;
    localparam int ADV_AW       = 24;
    // RULE_06: flag bit positions
    localparam int FLAG_I       = 7;
    localparam int FLAG_UM      = 6;
    localparam int FLAG_H       = 5;
    localparam int FLAG_U       = 4;
    localparam int FLAG_N       = 3;
    localparam int FLAG_Z       = 2;
    localparam int FLAG_V       = 1;
    localparam int FLAG_C       = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam logic [23:0] PC_RESET   = 24'h000000;

    // register view selector
    typedef enum logic [2:0] {
        VIEW_LONG = 3'h0,
        VIEW_EXT  = 3'h1,
        VIEW_WORD = 3'h2,
        VIEW_HIGH = 3'h3,
        VIEW_LOW  = 3'h4
    } crf_view_t;

    // operand size for arithmetic flags
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } crf_size_t;

    // flag operation
    typedef enum logic [2:0] {
        FOP_NONE  = 3'h0,
        FOP_ARITH = 3'h1,
        FOP_LOGIC = 3'h2,
        FOP_SHIFT = 3'h3,
        FOP_LOAD  = 3'h4,
        FOP_AND   = 3'h5,
        FOP_OR    = 3'h6,
        FOP_XOR   = 3'h7
    } crf_fop_t;

    // address mode
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_MBYTE  = 2'h1,
        MODE_ADV    = 2'h2
    } crf_mode_t;

    typedef struct packed {
        logic            en;
        logic [2:0]      idx;
        crf_view_t       view;
        logic [31:0]     data;
    } crf_gp_wr_t;

    typedef struct packed {
        crf_fop_t        op;
        crf_size_t       size;
        logic [31:0]     result;
        logic [31:0]     opA;
        logic [31:0]     opB;
        logic            isSub;
        logic            carryIn;
        logic            shiftOut;
        logic [7:0]      imm;
    } crf_flag_req_t;
endpackage

// File: core/crf_regfile.sv
// cpu register and flags file top: general registers, counter, flags
`timescale 1ns/10ps
// What this block does
// RULE_01: eight 32-bit general registers, three view widths
// RULE_02: each splits into extended and low halves
// RULE_03: low half splits into two bytes
// RULE_04: register seven doubles as stack pointer
// RULE_05: 24-bit counter, fetch lsb forced zero
// RULE_06: flag byte layout I, bit 6, H U N Z V C
// RULE_07: mask blocks interrupts except non-maskable
// RULE_08: exception entry sets the mask bit
// RULE_09: bit six software writable, also mask
// RULE_10: bit four plain software user bit
// RULE_11: half carry at bit 3/11/27
// RULE_12: negative takes result sign bit
// RULE_13: zero set when result is zero
// RULE_14: overflow set on arithmetic overflow
// RULE_15: carry from add, borrow, shift out
// RULE_16: carry acts as bit accumulator
// RULE_17: flags kept, or loaded and logic-modified
// RULE_18: branch decision from N Z V C
// RULE_19: reset loads counter vector, sets mask
// RULE_20: software sets stack pointer first after reset
// RULE_21: odd wide access forced to even
// RULE_22: normal 64 kbytes, advanced 16 Mbytes
// RULE_23: one-megabyte modes use 20-bit addresses
// RULE_24: BCD nibbles and bit numbers 0..7
// RULE_25: partial writes preserve other bits
module crf_regfile (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire crf_pkg::crf_gp_wr_t   gpWrite,
    input  wire logic [2:0]            rdIdxA,
    input  wire crf_pkg::crf_view_t    rdViewA,
    input  wire logic [2:0]            rdIdxB,
    output logic [31:0]                rdDataA,
    output logic [31:0]                rdDataB,
    output logic [31:0]                stackPointer,
    input  wire logic                  pcLoad,
    input  wire logic [23:0]           pcLoadValue,
    input  wire logic                  pcAdvance,
    input  wire logic [23:0]           resetVector,
    output logic [23:0]                program_counter,
    output logic [23:0]                fetchAddr,
    input  wire crf_pkg::crf_flag_req_t flagReq,
    input  wire logic                  bitAccWrite,
    input  wire logic                  bitAccValue,
    input  wire logic [2:0]            bitNum,
    input  wire logic [7:0]            bitByte,
    output logic                       bitSelected,
    input  wire logic                  excStart,
    output logic [7:0]                 condition_flags_reg,
    input  wire logic [3:0]            branchCond,
    output logic                       branchTaken,
    input  wire logic                  irqReq,
    input  wire logic                  nmiReq,
    output logic                       irqAccept,
    output logic                       userMaskBit,
    input  wire logic [7:0]            bcdByte,
    output logic [3:0]                 bcdHigh,
    output logic [3:0]                 bcdLow,
    input  wire crf_pkg::crf_mode_t    addrMode,
    input  wire logic [31:0]           effAddr,
    input  wire logic                  wideAccess,
    output logic [23:0]                busAddr
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [23:0] pc;
        logic [7:0]  flags;
        logic        rstPending;
        logic [31:0] viewA;
        logic        taken;
        logic        accept;
        logic        bitSel;
        logic [3:0]  bcdH;
        logic [3:0]  bcdL;
    } crf_top_state_t;

    crf_top_state_t st;
    crf_top_state_t next_st;
    logic [31:0]    bankA;

    // RULE_01: register bank instance
    crf_gp_bank #(
        .COUNT (crf_pkg::GP_COUNT)
    ) u_bank (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .wr           (gpWrite),
        .rdIdxA       (rdIdxA),
        .rdIdxB       (rdIdxB),
        .rdDataA      (bankA),
        .rdDataB      (rdDataB),
        .stackPointer (stackPointer)
    );

    crf_addr_gen u_agen (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .mode       (addrMode),
        .effAddr    (effAddr),
        .wideAccess (wideAccess),
        .busAddr    (busAddr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // size-dependent result pieces
    logic        msb;
    logic        zeroRes;
    logic        halfC;
    logic        fullC;
    logic        ovf;
    logic [32:0] sum;
    logic [28:0] sumH;
    logic [31:0] bEff;

    always_comb begin
        bEff = flagReq.isSub ? ~flagReq.opB : flagReq.opB;
        sum  = {1'b0, flagReq.opA} + {1'b0, bEff} + {32'h0, flagReq.isSub ^ flagReq.carryIn};
        sumH = {1'b0, flagReq.opA[27:0]} + {1'b0, bEff[27:0]}
             + {28'h0, flagReq.isSub ^ flagReq.carryIn};
        msb     = 1'b0;
        zeroRes = 1'b0;
        halfC   = 1'b0;
        fullC   = 1'b0;
        ovf     = 1'b0;
        case (flagReq.size)
            crf_pkg::SIZE_BYTE: begin
                msb     = flagReq.result[7];
                zeroRes = (flagReq.result[7:0] == 8'h00);
                // RULE_11: byte half carry at bit 3
                halfC   = (flagReq.opA[3:0] + bEff[3:0] + {3'h0, flagReq.isSub ^ flagReq.carryIn})
                          > 5'h0f;
                fullC   = ({1'b0, flagReq.opA[7:0]} + {1'b0, bEff[7:0]}
                          + {8'h00, flagReq.isSub ^ flagReq.carryIn}) > 9'h0ff;
                ovf     = (flagReq.opA[7] == bEff[7]) && (flagReq.result[7] != flagReq.opA[7]);
            end
            crf_pkg::SIZE_WORD: begin
                msb     = flagReq.result[15];
                zeroRes = (flagReq.result[15:0] == 16'h0000);
                // RULE_11: word half carry at bit 11
                halfC   = ({1'b0, flagReq.opA[11:0]} + {1'b0, bEff[11:0]}
                          + {12'h000, flagReq.isSub ^ flagReq.carryIn}) > 13'h0fff;
                fullC   = ({1'b0, flagReq.opA[15:0]} + {1'b0, bEff[15:0]}
                          + {16'h0000, flagReq.isSub ^ flagReq.carryIn}) > 17'h0ffff;
                ovf     = (flagReq.opA[15] == bEff[15])
                          && (flagReq.result[15] != flagReq.opA[15]);
            end
            default: begin
                msb     = flagReq.result[31];
                zeroRes = (flagReq.result == 32'h0);
                // RULE_11: long half carry at bit 27
                halfC   = sumH[28];
                fullC   = sum[32];
                ovf     = (flagReq.opA[31] == bEff[31])
                          && (flagReq.result[31] != flagReq.opA[31]);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    logic n;
    logic z;
    logic v;
    logic c;

    always_comb begin
        next_st = st;
        next_st.rstPending = 1'b0;
        // RULE_05: counter advance by one word
        if (st.rstPending) begin
            // RULE_19: reset vector fetch
            next_st.pc = resetVector;
        end else if (pcLoad) begin
            next_st.pc = pcLoadValue;
        end else if (pcAdvance) begin
            next_st.pc = st.pc + 24'h000002;
        end

        // RULE_17: flags untouched unless an op says so
        case (flagReq.op)
            crf_pkg::FOP_ARITH: begin
                next_st.flags[crf_pkg::FLAG_H] = flagReq.isSub ? ~halfC : halfC;
                // RULE_12: negative from sign bit
                next_st.flags[crf_pkg::FLAG_N] = msb;
                // RULE_13: zero flag from result
                next_st.flags[crf_pkg::FLAG_Z] = zeroRes;
                // RULE_14: overflow flag
                next_st.flags[crf_pkg::FLAG_V] = ovf;
                // RULE_15: borrow is inverted carry for subtract
                next_st.flags[crf_pkg::FLAG_C] = flagReq.isSub ? ~fullC : fullC;
            end
            crf_pkg::FOP_LOGIC: begin
                next_st.flags[crf_pkg::FLAG_N] = msb;
                next_st.flags[crf_pkg::FLAG_Z] = zeroRes;
                next_st.flags[crf_pkg::FLAG_V] = 1'b0;
            end
            crf_pkg::FOP_SHIFT: begin
                next_st.flags[crf_pkg::FLAG_N] = msb;
                next_st.flags[crf_pkg::FLAG_Z] = zeroRes;
                next_st.flags[crf_pkg::FLAG_V] = 1'b0;
                // RULE_15: shifted-out bit into carry
                next_st.flags[crf_pkg::FLAG_C] = flagReq.shiftOut;
            end
            // RULE_09: whole byte incl bits 6 and 4 by flag ops
            crf_pkg::FOP_LOAD: next_st.flags = flagReq.imm;
            crf_pkg::FOP_AND:  next_st.flags = st.flags & flagReq.imm;
            crf_pkg::FOP_OR:   next_st.flags = st.flags | flagReq.imm;
            // RULE_10: user bit only via flag ops
            crf_pkg::FOP_XOR:  next_st.flags = st.flags ^ flagReq.imm;
            default:           next_st.flags = st.flags;
        endcase

        // RULE_16: carry as bit accumulator
        if (bitAccWrite) begin
            next_st.flags[crf_pkg::FLAG_C] = bitAccValue;
        end
        // RULE_08: exception entry sets mask, wins over ops
        if (excStart) begin
            next_st.flags[crf_pkg::FLAG_I] = 1'b1;
        end

        // RULE_24: bit number selects one of eight
        next_st.bitSel = bitByte[bitNum];
        // RULE_24: BCD digit split
        next_st.bcdH = bcdByte[7:4];
        next_st.bcdL = bcdByte[3:0];

        // RULE_07: nmi bypasses mask
        next_st.accept = nmiReq || (irqReq && !st.flags[crf_pkg::FLAG_I]);

        // RULE_02: view selection for reads
        case (rdViewA)
            crf_pkg::VIEW_EXT:  next_st.viewA = {16'h0000, bankA[31:16]};
            crf_pkg::VIEW_WORD: next_st.viewA = {16'h0000, bankA[15:0]};
            // RULE_03: byte views
            crf_pkg::VIEW_HIGH: next_st.viewA = {24'h000000, bankA[15:8]};
            crf_pkg::VIEW_LOW:  next_st.viewA = {24'h000000, bankA[7:0]};
            default:            next_st.viewA = bankA;
        endcase

        n = st.flags[crf_pkg::FLAG_N];
        z = st.flags[crf_pkg::FLAG_Z];
        v = st.flags[crf_pkg::FLAG_V];
        c = st.flags[crf_pkg::FLAG_C];
        // RULE_18: branch conditions from N Z V C
        case (branchCond)
            4'h0: next_st.taken = 1'b1;
            4'h1: next_st.taken = 1'b0;
            4'h2: next_st.taken = !(c || z);
            4'h3: next_st.taken = c || z;
            4'h4: next_st.taken = !c;
            4'h5: next_st.taken = c;
            4'h6: next_st.taken = !z;
            4'h7: next_st.taken = z;
            4'h8: next_st.taken = !v;
            4'h9: next_st.taken = v;
            4'ha: next_st.taken = !n;
            4'hb: next_st.taken = n;
            4'hc: next_st.taken = !(n ^ v);
            4'hd: next_st.taken = n ^ v;
            4'he: next_st.taken = !(z || (n ^ v));
            default: next_st.taken = z || (n ^ v);
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // RULE_19: mask set, counter reloaded after release
            st            <= '0;
            st.pc         <= crf_pkg::PC_RESET;
            st.flags      <= crf_pkg::FLAGS_RESET;
            st.rstPending <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rdDataA             = st.viewA;
    assign program_counter     = st.pc;
    // RULE_05: fetch ignores counter lsb
    assign fetchAddr           = {st.pc[23:1], 1'b0};
    assign condition_flags_reg = st.flags;
    assign branchTaken         = st.taken;
    assign irqAccept           = st.accept;
    assign userMaskBit         = st.flags[crf_pkg::FLAG_UM];
    assign bitSelected         = st.bitSel;
    assign bcdHigh             = st.bcdH;
    assign bcdLow              = st.bcdL;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_exc;
        excStart;
    endsequence
    property p_exc_mask;
        @(posedge core_clk) disable iff (!rst_b)
        s_exc |=> condition_flags_reg[7];
    endproperty
    a_exc_mask: assert property (p_exc_mask) else $error("mask not set"); // RULE_08
    property p_nmi;
        @(posedge core_clk) disable iff (!rst_b)
        nmiReq |=> irqAccept;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi lost"); // RULE_07
    property p_masked;
        @(posedge core_clk) disable iff (!rst_b)
        (!nmiReq && condition_flags_reg[7]) |=> !irqAccept;
    endproperty
    a_masked: assert property (p_masked) else $error("masked irq taken"); // RULE_07
    property p_fetch;
        @(posedge core_clk) disable iff (!rst_b)
        fetchAddr[0] == 1'b0 && fetchAddr[23:1] == program_counter[23:1];
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch lsb"); // RULE_05
    property p_reset_vec;
        @(posedge core_clk)
        (!rst_b ##1 rst_b) |=> program_counter == $past(resetVector);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("vector not loaded"); // RULE_19
    property p_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (flagReq.op == crf_pkg::FOP_NONE && !excStart && !bitAccWrite)
        |=> $stable(condition_flags_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("flags changed"); // RULE_17
    property p_xor;
        @(posedge core_clk) disable iff (!rst_b)
        (flagReq.op == crf_pkg::FOP_XOR && !excStart && !bitAccWrite)
        |=> condition_flags_reg == ($past(condition_flags_reg) ^ $past(flagReq.imm));
    endproperty
    a_xor: assert property (p_xor) else $error("xor flags"); // RULE_17
    property p_bitacc;
        @(posedge core_clk) disable iff (!rst_b)
        bitAccWrite |=> condition_flags_reg[0] == $past(bitAccValue);
    endproperty
    a_bitacc: assert property (p_bitacc) else $error("bit acc"); // RULE_16
    property p_wide;
        @(posedge core_clk) disable iff (!rst_b)
        wideAccess |=> busAddr[0] == 1'b0;
    endproperty
    a_wide: assert property (p_wide) else $error("odd wide addr"); // RULE_21
    property p_normal;
        @(posedge core_clk) disable iff (!rst_b)
        addrMode == crf_pkg::MODE_NORMAL |=> busAddr[23:16] == 8'h00;
    endproperty
    a_normal: assert property (p_normal) else $error("normal range"); // RULE_22
endmodule

// File: verification/tb_crf_regfile.sv
// self-checking bench for the register and flags file
`timescale 1ns/10ps
module tb_crf_regfile;
    logic                   core_clk;
    logic                   rst_b;
    crf_pkg::crf_gp_wr_t    gpWrite;
    logic [2:0]             rdIdxA;
    crf_pkg::crf_view_t     rdViewA;
    logic [2:0]             rdIdxB;
    logic [31:0]            rdDataA;
    logic [31:0]            rdDataB;
    logic [31:0]            stackPointer;
    logic                   pcLoad;
    logic [23:0]            pcLoadValue;
    logic                   pcAdvance;
    logic [23:0]            resetVector;
    logic [23:0]            program_counter;
    logic [23:0]            fetchAddr;
    crf_pkg::crf_flag_req_t flagReq;
    logic                   bitAccWrite;
    logic                   bitAccValue;
    logic [2:0]             bitNum;
    logic [7:0]             bitByte;
    logic                   bitSelected;
    logic                   excStart;
    logic [7:0]             condition_flags_reg;
    logic [3:0]             branchCond;
    logic                   branchTaken;
    logic                   irqReq;
    logic                   nmiReq;
    logic                   irqAccept;
    logic                   userMaskBit;
    logic [7:0]             bcdByte;
    logic [3:0]             bcdHigh;
    logic [3:0]             bcdLow;
    crf_pkg::crf_mode_t     addrMode;
    logic [31:0]            effAddr;
    logic                   wideAccess;
    logic [23:0]            busAddr;
    int                     nMismatch;
    int                     testsRun;
    int                     cycles;

    crf_regfile dut (
        .core_clk, .rst_b, .gpWrite, .rdIdxA, .rdViewA, .rdIdxB, .rdDataA, .rdDataB,
        .stackPointer, .pcLoad, .pcLoadValue, .pcAdvance, .resetVector, .program_counter,
        .fetchAddr, .flagReq, .bitAccWrite, .bitAccValue, .bitNum, .bitByte, .bitSelected,
        .excStart, .condition_flags_reg, .branchCond, .branchTaken, .irqReq, .nmiReq,
        .irqAccept, .userMaskBit, .bcdByte, .bcdHigh, .bcdLow, .addrMode, .effAddr,
        .wideAccess, .busAddr
    );

    //////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (nMismatch == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic gpw(input logic [2:0] i, input crf_pkg::crf_view_t v, input logic [31:0] d);
        gpWrite = '{en: 1'b1, idx: i, view: v, data: d};
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [2:0] i, input crf_pkg::crf_view_t v,
                      input logic [31:0] ea, input logic [31:0] eb);
        gpWrite.en = 1'b0;
        rdIdxA = i;
        rdViewA = v;
        rdIdxB = i;
        @(negedge core_clk);
        chk("view read", ea, rdDataA);
        chk("full read", eb, rdDataB);
    endtask

    // carryIn stays 0, so a subtract reports borrow through the carry flag
    task automatic fop(input crf_pkg::crf_fop_t op, input crf_pkg::crf_size_t sz,
                       input logic [31:0] a, input logic [31:0] b, input logic [31:0] r,
                       input logic sub, input logic [7:0] imm, input logic [7:0] exp);
        flagReq = '{op: op, size: sz, result: r, opA: a, opB: b, isSub: sub,
                    carryIn: 1'b0, shiftOut: 1'b1, imm: imm};
        @(negedge core_clk);
        chk("flags", exp, condition_flags_reg);
    endtask

    task automatic adr(input crf_pkg::crf_mode_t m, input logic [31:0] ea, input logic w,
                       input logic [23:0] exp);
        addrMode = m;
        effAddr = ea;
        wideAccess = w;
        @(negedge core_clk);
        chk("bus address", exp, busAddr);
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // hang guard: the whole sequence needs well under 200 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            summarize();
        end
    end

    initial begin
        {rst_b, pcLoad, pcAdvance, bitAccWrite, bitAccValue, excStart, irqReq, nmiReq} = '0;
        {gpWrite, flagReq, rdIdxA, rdIdxB, bitNum, branchCond, effAddr, wideAccess} = '0;
        {rdViewA, addrMode, pcLoadValue, bcdByte} = '0;
        resetVector = 24'h0001a3;
        bitByte = 8'h96;
        nMismatch = 0;
        testsRun = 0;
        cycles = 0;
        repeat (6) @(negedge core_clk);
        chk("flags in reset", 8'h80, condition_flags_reg);
        rst_b = 1'b1;
        @(negedge core_clk);
        chk("counter", 24'h0001a3, program_counter);
        chk("fetch address", 24'h0001a2, fetchAddr);
        @(negedge core_clk);
        gpw(3'h3, crf_pkg::VIEW_LONG, 32'h12345678);
        gpw(3'h3, crf_pkg::VIEW_EXT, 32'h0000abcd);
        rd(3'h3, crf_pkg::VIEW_EXT, 32'h0000abcd, 32'habcd5678);
        gpw(3'h3, crf_pkg::VIEW_HIGH, 32'h0000009a);
        rd(3'h3, crf_pkg::VIEW_HIGH, 32'h0000009a, 32'habcd9a78);
        gpw(3'h3, crf_pkg::VIEW_LOW, 32'h00000055);
        rd(3'h3, crf_pkg::VIEW_LOW, 32'h00000055, 32'habcd9a55);
        rd(3'h3, crf_pkg::VIEW_WORD, 32'h00009a55, 32'habcd9a55);
        gpw(3'h7, crf_pkg::VIEW_LONG, 32'h00fffe00);
        chk("stack pointer", 32'h00fffe00, stackPointer);
        rd(3'h7, crf_pkg::VIEW_LONG, 32'h00fffe00, 32'h00fffe00);
        fop(crf_pkg::FOP_LOAD, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'h00, 8'h00);
        fop(crf_pkg::FOP_ARITH, crf_pkg::SIZE_BYTE, 32'h0f, 32'h01, 32'h10, 0, 0, 8'h20);
        fop(crf_pkg::FOP_ARITH, crf_pkg::SIZE_WORD, 32'h0fff, 32'h1, 32'h1000, 0, 0, 8'h20);
        fop(crf_pkg::FOP_ARITH, crf_pkg::SIZE_LONG, 32'h7fffffff, 32'h1, 32'h80000000,
            0, 0, 8'h2a);
        fop(crf_pkg::FOP_ARITH, crf_pkg::SIZE_BYTE, 32'hff, 32'h01, 32'h00, 0, 0, 8'h25);
        fop(crf_pkg::FOP_ARITH, crf_pkg::SIZE_BYTE, 32'h10, 32'h01, 32'h0f, 1, 0, 8'h20);
        fop(crf_pkg::FOP_ARITH, crf_pkg::SIZE_BYTE, 32'h00, 32'h01, 32'hff, 1, 0, 8'h29);
        fop(crf_pkg::FOP_LOAD, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'h5a, 8'h5a);
        chk("user mask", 1'b1, userMaskBit);
        fop(crf_pkg::FOP_AND, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'h0f, 8'h0a);
        fop(crf_pkg::FOP_OR, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'h50, 8'h5a);
        fop(crf_pkg::FOP_XOR, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'hff, 8'ha5);
        fop(crf_pkg::FOP_LOAD, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'h00, 8'h00);
        fop(crf_pkg::FOP_SHIFT, crf_pkg::SIZE_BYTE, 0, 0, 32'h80, 0, 0, 8'h09);
        flagReq.op = crf_pkg::FOP_NONE;
        bitAccWrite = 1'b1;
        @(negedge core_clk);
        bitAccWrite = 1'b0;
        chk("bit accumulator", 8'h08, condition_flags_reg);
        fop(crf_pkg::FOP_LOAD, crf_pkg::SIZE_BYTE, 0, 0, 0, 0, 8'h04, 8'h04);
        flagReq.op = crf_pkg::FOP_NONE;
        // zero set only: expected taken pattern, code 0 in bit 0
        for (int k = 0; k < 16; k++) begin
            branchCond = k[3:0];
            @(negedge core_clk);
            chk("branch", 16'h9599 >> k & 1, branchTaken);
        end
        irqReq = 1'b1;
        @(negedge core_clk);
        chk("irq open", 1'b1, irqAccept);
        excStart = 1'b1;
        @(negedge core_clk);
        excStart = 1'b0;
        chk("exception mask", 8'h84, condition_flags_reg);
        @(negedge core_clk);
        chk("irq masked", 1'b0, irqAccept);
        nmiReq = 1'b1;
        @(negedge core_clk);
        chk("nmi", 1'b1, irqAccept);
        flagReq.op = crf_pkg::FOP_LOAD;
        excStart = 1'b1;
        @(negedge core_clk);
        {excStart, flagReq.op} = '0;
        chk("exception priority", 8'h84, condition_flags_reg);
        for (int k = 0; k < 8; k++) begin
            bitNum = k[2:0];
            @(negedge core_clk);
            chk("bit select", bitByte[k], bitSelected);
        end
        bcdByte = 8'h93;
        @(negedge core_clk);
        chk("bcd digits", 8'h93, {bcdHigh, bcdLow});
        adr(crf_pkg::MODE_NORMAL, 32'h00123457, 1'b1, 24'h003456);
        adr(crf_pkg::MODE_NORMAL, 32'h00123457, 1'b0, 24'h003457);
        adr(crf_pkg::MODE_MBYTE, 32'hff123457, 1'b1, 24'h023456);
        adr(crf_pkg::MODE_ADV, 32'hffabcdef, 1'b1, 24'habcdee);
        adr(crf_pkg::MODE_ADV, 32'hffabcdef, 1'b0, 24'habcdef);
        pcLoad = 1'b1;
        pcLoadValue = 24'h000105;
        @(negedge core_clk);
        pcLoad = 1'b0;
        pcAdvance = 1'b1;
        @(negedge core_clk);
        pcAdvance = 1'b0;
        chk("counter", 24'h000107, program_counter);
        chk("fetch address", 24'h000106, fetchAddr);
        summarize();
    end
endmodule
